// ### include/scc_params.svh
`ifndef SCC_PARAMS_SVH
`define SCC_PARAMS_SVH

// ==========================================
// sizing
`define SCC_NSLOT 8
`define SCC_MAXPORTS 8'h08
`define SCC_MAXINTRS 10'h004
`define SCC_MAX_ADDR 127

// ==========================================
// dword 0 fields
`define SCC_SPEED_MSB 23
`define SCC_SPEED_LSB 20
`define SCC_MTT_BIT 25
`define SCC_HUB_BIT 26
`define SCC_CTXE_MSB 31
`define SCC_CTXE_LSB 27

// ==========================================
// dword 1 fields
`define SCC_EXLAT_MSB 15
`define SCC_EXLAT_LSB 0
`define SCC_RPORT_MSB 23
`define SCC_RPORT_LSB 16
`define SCC_NPORTS_MSB 31
`define SCC_NPORTS_LSB 24

// ==========================================
// dword 2 fields
`define SCC_TTHUB_MSB 7
`define SCC_TTHUB_LSB 0
`define SCC_TTPORT_MSB 15
`define SCC_TTPORT_LSB 8
`define SCC_TTT_MSB 17
`define SCC_TTT_LSB 16
`define SCC_INTR_MSB 31
`define SCC_INTR_LSB 22

// ==========================================
// dword 3 fields
`define SCC_ADDR_MSB 7
`define SCC_ADDR_LSB 0
`define SCC_STATE_MSB 31
`define SCC_STATE_LSB 27

// ==========================================
// slot state codes and reset value
`define SCC_ST_DISABLED 5'h00
`define SCC_ST_DEFAULT 5'h01
`define SCC_ST_ADDRESSED 5'h02
`define SCC_ST_CONFIGURED 5'h03
`define SCC_CTX_RESET 32'h0000_0000

// ==========================================
// speed codes, commands, completion codes
`define SCC_SPD_FS 4'h1
`define SCC_SPD_LS 4'h2
`define SCC_SPD_HS 4'h3
`define SCC_CMD_NOP 2'h0
`define SCC_CMD_ADDR_DEV 2'h1
`define SCC_CMD_CONFIG_EP 2'h2
`define SCC_CMD_DISABLE 2'h3
`define SCC_CC_SUCCESS 8'h01
`define SCC_CC_PARAM_ERR 8'h02
`define SCC_CC_CTX_STATE_ERR 8'h03

// ==========================================
// context sizes in bytes
`define SCC_CTX_BYTES_32 7'h20
`define SCC_CTX_BYTES_64 7'h40

`endif

// ### include/scc_pkg.sv
`include "scc_params.svh"

// ==========================================
// shared types and field helpers
package scc_pkg;
   typedef logic [31:0] scc_dw_t;    // one context dword
   typedef logic [2:0] scc_sidx_t;   // slot index
   typedef logic [1:0] scc_cmd_t;    // command code
   typedef enum logic [0:0] {SCC_IDLE, SCC_EXEC} scc_fsm_e;

   // slot state field of dword 3
   function automatic logic [4:0] scc_state_of(input scc_dw_t dw);
      return dw[`SCC_STATE_MSB:`SCC_STATE_LSB];
   endfunction

   // speed field of dword 0
   function automatic logic [3:0] scc_speed_of(input scc_dw_t dw);
      return dw[`SCC_SPEED_MSB:`SCC_SPEED_LSB];
   endfunction

   // low or full speed device
   function automatic logic scc_is_lsfs(input logic [3:0] spd);
      return (spd == `SCC_SPD_FS) || (spd == `SCC_SPD_LS);
   endfunction

   // slot holds an assigned address
   function automatic logic scc_has_addr(input scc_dw_t dw);
      return (scc_state_of(dw) == `SCC_ST_ADDRESSED) ||
             (scc_state_of(dw) == `SCC_ST_CONFIGURED);
   endfunction
endpackage

// ### include/scc_ctx_if.sv
`timescale 1ns/1ps
`default_nettype none
`include "scc_params.svh"

// ==========================================
// context arrays shared with the helpers
interface scc_ctx_if;
   import scc_pkg::*;
   scc_dw_t dw0 [`SCC_NSLOT];            // output dword 0 per slot
   scc_dw_t dw1 [`SCC_NSLOT];            // output dword 1 per slot
   scc_dw_t dw2 [`SCC_NSLOT];            // output dword 2 per slot
   scc_dw_t dw3 [`SCC_NSLOT];            // output dword 3 per slot
   logic [`SCC_NSLOT-1:0] ring_busy;     // periodic rings not empty
   scc_sidx_t pick_slot;                 // slot being addressed
   logic [7:0] pick_port;                // its root port
   logic [7:0] pick_addr;                // free address found
   logic pick_ok;                        // a free address exists
   scc_sidx_t tok_slot;                  // slot for token lookup
   logic [3:0] tok_speed;                // token speed
   logic [7:0] tok_hub_slot;             // translator hub slot
   logic [7:0] tok_port;                 // translator port
   logic tok_split;                      // split token needed
   logic ping_ok;                        // pings may be issued
   logic [15:0] tok_exlat;               // exit latency

   modport picker(input dw3, input dw1, input pick_slot, input pick_port,
                  output pick_addr, output pick_ok);
   modport tokener(input dw0, input dw1, input dw2, input dw3, input ring_busy,
                   input tok_slot, output tok_speed, output tok_hub_slot,
                   output tok_port, output tok_split, output ping_ok, output tok_exlat);
endinterface

`default_nettype wire

// ### src/scc_addr_pick.sv
`timescale 1ns/1ps
`default_nettype none
`include "scc_params.svh"

// ==========================================
// lowest device address free on one root port
module scc_addr_pick (
   // context view
   scc_ctx_if.picker p
);
   import scc_pkg::*;

   // address already held by another slot on the same root port
   function automatic logic addr_taken(input logic [7:0] a);
      logic hit;
      hit = 1'b0;
      for (int s = 0; s < `SCC_NSLOT; s++) begin
         if ((3'(s) != p.pick_slot) && scc_has_addr(p.dw3[s]) &&
             (p.dw1[s][`SCC_RPORT_MSB:`SCC_RPORT_LSB] == p.pick_port) &&
             (p.dw3[s][`SCC_ADDR_MSB:`SCC_ADDR_LSB] == a)) begin
            hit = 1'b1;
         end
      end
      return hit;
   endfunction

   // scan downward so the lowest free address wins
   always_comb begin
      p.pick_ok = 1'b0;
      p.pick_addr = 8'h00;
      for (int a = `SCC_MAX_ADDR; a >= 1; a--) begin
         if (!addr_taken(8'(a))) begin
            p.pick_ok = 1'b1;
            p.pick_addr = 8'(a);
         end
      end
   end
endmodule

`default_nettype wire

// ### src/scc_token.sv
`timescale 1ns/1ps
`default_nettype none
`include "scc_params.svh"

// ==========================================
// split token fields and ping gating per slot
module scc_token (
   // context view
   scc_ctx_if.tokener t
);
   import scc_pkg::*;

   // field lookup for the selected slot
   always_comb begin
      t.tok_speed = scc_speed_of(t.dw0[t.tok_slot]);
      t.tok_hub_slot = t.dw2[t.tok_slot][`SCC_TTHUB_MSB:`SCC_TTHUB_LSB];
      t.tok_port = t.dw2[t.tok_slot][`SCC_TTPORT_MSB:`SCC_TTPORT_LSB];
      // split only for ls/fs behind a translator hub
      t.tok_split = scc_is_lsfs(t.tok_speed) && (t.tok_hub_slot != 8'h00) &&
                    scc_has_addr(t.dw3[t.tok_slot]);
      t.tok_exlat = t.dw1[t.tok_slot][`SCC_EXLAT_MSB:`SCC_EXLAT_LSB];
      // no pings while periodic rings are empty
      t.ping_ok = t.ring_busy[t.tok_slot] &&
                  (scc_state_of(t.dw3[t.tok_slot]) == `SCC_ST_CONFIGURED);
   end
endmodule

`default_nettype wire

// ### src/scc_slot_ctx_checker.sv
`timescale 1ns/1ps
`default_nettype none
`include "scc_params.svh"

// How it works
// - address written only after successful set address
// - address invalid while disabled or default
// - slot state field updated on every transition
// - context 32 or 64 bytes by size flag
// - split token from speed, hub slot, port
// - address plus root port unique across slots
// - busy periodic rings on a configured slot drive pings, none when idle
// - address device overwrites whole output context
// - configure needs addressed or configured state
// - configure writes entries, state, hub fields

module scc_slot_ctx_checker (
   // clock and reset
   input wire logic clk,
   input wire logic rstn,
   // command request
   input wire logic cmd_valid,
   input wire scc_pkg::scc_cmd_t cmd_type,
   input wire scc_pkg::scc_sidx_t cmd_slot,
   input wire scc_pkg::scc_dw_t cmd_in_dw0,
   input wire scc_pkg::scc_dw_t cmd_in_dw1,
   input wire scc_pkg::scc_dw_t cmd_in_dw2,
   input wire scc_pkg::scc_dw_t cmd_in_dw3,
   input wire logic cmd_set_addr_ok,
   // command completion
   output logic cmd_ready,
   output logic cmd_done,
   output logic [7:0] cmd_code,
   output logic [7:0] cmd_addr,
   // context read port
   input wire scc_pkg::scc_sidx_t rd_slot,
   input wire logic [3:0] rd_word,
   input wire logic ctx_size_64,
   output scc_pkg::scc_dw_t rd_data,
   output logic rd_addr_valid,
   output logic [6:0] ctx_bytes,
   // token and ping lookup
   input wire scc_pkg::scc_sidx_t tok_slot,
   input wire logic [`SCC_NSLOT-1:0] ring_busy,
   output logic [3:0] tok_speed,
   output logic [7:0] tok_hub_slot,
   output logic [7:0] tok_port,
   output logic tok_split,
   output logic ping_ok,
   output logic [15:0] tok_exlat
);
   import scc_pkg::*;

   // ==========================================
   // helpers
   scc_ctx_if cx ();                 // shared context view

   scc_addr_pick u_pick (
      .p (cx.picker)
   );

   scc_token u_tok (
      .t (cx.tokener)
   );

   // ==========================================
   // state
   scc_fsm_e fsm, next_fsm;          // command sequencer
   scc_cmd_t lat_type, next_lat_type;    // latched command
   scc_sidx_t lat_slot, next_lat_slot;   // latched slot
   scc_dw_t lat_in0, next_lat_in0;   // latched input dword 0
   scc_dw_t lat_in1, next_lat_in1;   // latched input dword 1
   scc_dw_t lat_in2, next_lat_in2;   // latched input dword 2
   scc_dw_t lat_in3, next_lat_in3;   // latched input dword 3
   logic lat_ok, next_lat_ok;        // latched set address result
   logic next_cmd_ready;             // ready next cycle
   logic next_cmd_done;              // done pulse next cycle
   logic [7:0] next_cmd_code;        // completion code next
   logic [7:0] next_cmd_addr;        // reported address next

   scc_dw_t ctx0 [`SCC_NSLOT], next_ctx0 [`SCC_NSLOT];   // output dword 0
   scc_dw_t ctx1 [`SCC_NSLOT], next_ctx1 [`SCC_NSLOT];   // output dword 1
   scc_dw_t ctx2 [`SCC_NSLOT], next_ctx2 [`SCC_NSLOT];   // output dword 2
   scc_dw_t ctx3 [`SCC_NSLOT], next_ctx3 [`SCC_NSLOT];   // output dword 3

   scc_dw_t next_rd_data;            // read word next
   logic next_rd_addr_valid;         // address meaning next
   logic [6:0] next_ctx_bytes;       // context size next

   // ==========================================
   // execution decision
   logic [4:0] cur_state;            // state of latched slot
   logic [3:0] in_speed;             // speed from input
   logic in_hub;                     // hub flag from input
   logic [7:0] in_tthub;             // translator hub slot in input
   logic ex_write;                   // commit new dwords
   logic [7:0] ex_code;              // completion code
   scc_dw_t ex0, ex1, ex2, ex3;      // new dwords

   // drive the shared view
   always_comb begin
      cx.dw0 = ctx0;
      cx.dw1 = ctx1;
      cx.dw2 = ctx2;
      cx.dw3 = ctx3;
      cx.ring_busy = ring_busy;
      cx.pick_slot = lat_slot;
      cx.pick_port = lat_in1[`SCC_RPORT_MSB:`SCC_RPORT_LSB];
      cx.tok_slot = tok_slot;
   end

   // checks and new context values for the latched command
   always_comb begin
      cur_state = scc_state_of(ctx3[lat_slot]);
      in_speed = scc_speed_of(lat_in0);
      in_hub = lat_in0[`SCC_HUB_BIT];
      in_tthub = lat_in2[`SCC_TTHUB_MSB:`SCC_TTHUB_LSB];
      ex_write = 1'b0;
      ex_code = `SCC_CC_SUCCESS;
      ex0 = ctx0[lat_slot];
      ex1 = ctx1[lat_slot];
      ex2 = ctx2[lat_slot];
      ex3 = ctx3[lat_slot];
      unique case (lat_type)
         `SCC_CMD_ADDR_DEV: begin
            if ((cur_state != `SCC_ST_DISABLED) && (cur_state != `SCC_ST_DEFAULT)) begin
               ex_code = `SCC_CC_CTX_STATE_ERR;
            end else if (lat_in3 != `SCC_CTX_RESET) begin
               ex_code = `SCC_CC_PARAM_ERR;
            end else if ((lat_in0[`SCC_CTXE_MSB:`SCC_CTXE_LSB] != 5'h01) ||
                         (cx.pick_port == 8'h00) ||
                         (cx.pick_port > `SCC_MAXPORTS) ||
                         (lat_in2[`SCC_INTR_MSB:`SCC_INTR_LSB] >= `SCC_MAXINTRS) ||
                         (lat_in1[`SCC_NPORTS_MSB:`SCC_NPORTS_LSB] != 8'h00)) begin
               ex_code = `SCC_CC_PARAM_ERR;
            end else if (scc_is_lsfs(in_speed) && (in_tthub != 8'h00) &&
                         ((in_tthub > 8'(`SCC_NSLOT)) ||
                          !ctx0[3'(in_tthub - 8'h01)][`SCC_HUB_BIT])) begin
               ex_code = `SCC_CC_PARAM_ERR;
            end else if (!cx.pick_ok) begin
               ex_code = `SCC_CC_PARAM_ERR;
            end else begin
               // whole output context rewritten, dwords 0 to 2 from input
               ex_write = 1'b1;
               ex0 = lat_in0;
               ex1 = lat_in1;
               ex2 = lat_in2;
               if (lat_ok) begin
                  ex3 = {`SCC_ST_ADDRESSED, 19'h0_0000, cx.pick_addr};
               end else begin
                  ex3 = {`SCC_ST_DEFAULT, 19'h0_0000, 8'h00};
               end
            end
         end
         `SCC_CMD_CONFIG_EP: begin
            if ((cur_state != `SCC_ST_ADDRESSED) && (cur_state != `SCC_ST_CONFIGURED)) begin
               ex_code = `SCC_CC_CTX_STATE_ERR;
            end else if (!in_hub &&
                         (lat_in1[`SCC_NPORTS_MSB:`SCC_NPORTS_LSB] != 8'h00)) begin
               ex_code = `SCC_CC_PARAM_ERR;
            end else begin
               ex_write = 1'b1;
               // entries from input, state to configured
               ex0[`SCC_CTXE_MSB:`SCC_CTXE_LSB] = lat_in0[`SCC_CTXE_MSB:`SCC_CTXE_LSB];
               ex3[`SCC_STATE_MSB:`SCC_STATE_LSB] = `SCC_ST_CONFIGURED;
               if (in_hub) begin
                  ex0[`SCC_HUB_BIT] = 1'b1;
                  ex1[`SCC_NPORTS_MSB:`SCC_NPORTS_LSB] =
                     lat_in1[`SCC_NPORTS_MSB:`SCC_NPORTS_LSB];
                  if (in_speed == `SCC_SPD_HS) begin
                     ex0[`SCC_MTT_BIT] = lat_in0[`SCC_MTT_BIT];
                     ex2[`SCC_TTT_MSB:`SCC_TTT_LSB] = lat_in2[`SCC_TTT_MSB:`SCC_TTT_LSB];
                  end
               end
            end
         end
         `SCC_CMD_DISABLE: begin
            // slot back to disabled, address freed
            ex_write = 1'b1;
            ex3 = `SCC_CTX_RESET;
         end
         `SCC_CMD_NOP: begin
            ex_code = `SCC_CC_SUCCESS;
         end
      endcase
   end

   // ==========================================
   // command sequencer next values
   always_comb begin
      next_fsm = fsm;
      next_lat_type = lat_type;
      next_lat_slot = lat_slot;
      next_lat_in0 = lat_in0;
      next_lat_in1 = lat_in1;
      next_lat_in2 = lat_in2;
      next_lat_in3 = lat_in3;
      next_lat_ok = lat_ok;
      next_cmd_ready = cmd_ready;
      next_cmd_done = 1'b0;
      next_cmd_code = cmd_code;
      next_cmd_addr = cmd_addr;
      unique case (fsm)
         SCC_IDLE: begin
            next_cmd_ready = 1'b1; // ready whenever idle
            // take a command while ready
            if (cmd_valid && cmd_ready) begin
               next_fsm = SCC_EXEC;
               next_lat_type = cmd_type;
               next_lat_slot = cmd_slot;
               next_lat_in0 = cmd_in_dw0;
               next_lat_in1 = cmd_in_dw1;
               next_lat_in2 = cmd_in_dw2;
               next_lat_in3 = cmd_in_dw3;
               next_lat_ok = cmd_set_addr_ok;
               next_cmd_ready = 1'b0;
            end
         end
         SCC_EXEC: begin
            // report and return to idle
            next_fsm = SCC_IDLE;
            next_cmd_ready = 1'b1;
            next_cmd_done = 1'b1;
            next_cmd_code = ex_code;
            next_cmd_addr = ex3[`SCC_ADDR_MSB:`SCC_ADDR_LSB];
         end
      endcase
   end

   // command sequencer registers
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         fsm <= SCC_IDLE;
         lat_type <= `SCC_CMD_NOP;
         lat_slot <= 3'h0;
         lat_in0 <= `SCC_CTX_RESET;
         lat_in1 <= `SCC_CTX_RESET;
         lat_in2 <= `SCC_CTX_RESET;
         lat_in3 <= `SCC_CTX_RESET;
         lat_ok <= 1'b0;
         cmd_ready <= 1'b0;
         cmd_done <= 1'b0;
         cmd_code <= 8'h00;
         cmd_addr <= 8'h00;
      end else begin
         fsm <= next_fsm;
         lat_type <= next_lat_type;
         lat_slot <= next_lat_slot;
         lat_in0 <= next_lat_in0;
         lat_in1 <= next_lat_in1;
         lat_in2 <= next_lat_in2;
         lat_in3 <= next_lat_in3;
         lat_ok <= next_lat_ok;
         cmd_ready <= next_cmd_ready;
         cmd_done <= next_cmd_done;
         cmd_code <= next_cmd_code;
         cmd_addr <= next_cmd_addr;
      end
   end

   // ==========================================
   // context storage next values
   always_comb begin
      next_ctx0 = ctx0;
      next_ctx1 = ctx1;
      next_ctx2 = ctx2;
      next_ctx3 = ctx3;
      // errors leave the output context untouched
      if ((fsm == SCC_EXEC) && ex_write) begin
         next_ctx0[lat_slot] = ex0;
         next_ctx1[lat_slot] = ex1;
         next_ctx2[lat_slot] = ex2;
         next_ctx3[lat_slot] = ex3;
      end
   end

   // context storage registers, zero means disabled
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         for (int s = 0; s < `SCC_NSLOT; s++) begin
            ctx0[s] <= `SCC_CTX_RESET;
            ctx1[s] <= `SCC_CTX_RESET;
            ctx2[s] <= `SCC_CTX_RESET;
            ctx3[s] <= `SCC_CTX_RESET;
         end
      end else begin
         ctx0 <= next_ctx0;
         ctx1 <= next_ctx1;
         ctx2 <= next_ctx2;
         ctx3 <= next_ctx3;
      end
   end

   // ==========================================
   // read port and lookup next values
   always_comb begin
      unique case (rd_word)
         4'h0: next_rd_data = ctx0[rd_slot];
         4'h1: next_rd_data = ctx1[rd_slot];
         4'h2: next_rd_data = ctx2[rd_slot];
         4'h3: next_rd_data = ctx3[rd_slot];
         // private words and the upper half read as zero
         default: next_rd_data = `SCC_CTX_RESET;
      endcase
      next_rd_addr_valid = scc_has_addr(ctx3[rd_slot]);
      next_ctx_bytes = ctx_size_64 ? `SCC_CTX_BYTES_64 : `SCC_CTX_BYTES_32;
   end

   // read port and lookup registers
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rd_data <= `SCC_CTX_RESET;
         rd_addr_valid <= 1'b0;
         ctx_bytes <= `SCC_CTX_BYTES_32;
         tok_speed <= 4'h0;
         tok_hub_slot <= 8'h00;
         tok_port <= 8'h00;
         tok_split <= 1'b0;
         ping_ok <= 1'b0;
         tok_exlat <= 16'h0000;
      end else begin
         rd_data <= next_rd_data;
         rd_addr_valid <= next_rd_addr_valid;
         ctx_bytes <= next_ctx_bytes;
         tok_speed <= cx.tok_speed;
         tok_hub_slot <= cx.tok_hub_slot;
         tok_port <= cx.tok_port;
         tok_split <= cx.tok_split;
         ping_ok <= cx.ping_ok;
         tok_exlat <= cx.tok_exlat;
      end
   end
endmodule

`default_nettype wire

// ### verification/scc_sw_model.sv
`timescale 1ns/1ps
`default_nettype none
`include "scc_params.svh"

// ==========================================
// software side: builds the input slot context
module scc_sw_model (
   // what the bench asks for
   input wire logic cfg,
   input wire logic [3:0] speed,
   input wire logic [7:0] val,
   input wire logic [7:0] tt_hub,
   // input context dwords
   output scc_pkg::scc_dw_t dw0,
   output scc_pkg::scc_dw_t dw1,
   output scc_pkg::scc_dw_t dw2,
   output scc_pkg::scc_dw_t dw3
);
   import scc_pkg::*;
   logic hub; // hub flag only on configure
   assign hub = cfg && (val != 8'h00);
   // entries 1 for address device, else last endpoint index
   assign dw0 = {cfg ? 5'h02 : 5'h01, hub, 2'h0, speed, 20'h00000};
   // val is root port or, with hub, number of ports
   assign dw1 = {hub ? val : 8'h00, cfg ? 8'h00 : val, 16'h0000};
   // translator port only beside a hub id
   assign dw2 = {16'h0000, (tt_hub != 8'h00) ? 8'h01 : 8'h00, tt_hub};
   assign dw3 = 32'h0000_0000;
endmodule

`default_nettype wire

// ### verification/scc_chk_sva.sv
`timescale 1ns/1ps
`default_nettype none
`include "scc_params.svh"

// ==========================================
// port level checks
module scc_chk_sva (
   input wire logic clk,
   input wire logic rstn,
   input wire logic cmd_valid,
   input wire logic cmd_ready,
   input wire logic cmd_done,
   input wire logic [7:0] cmd_code,
   input wire logic [7:0] cmd_addr,
   input wire logic [3:0] rd_word,
   input wire logic ctx_size_64,
   input wire scc_pkg::scc_dw_t rd_data,
   input wire logic rd_addr_valid,
   input wire logic [6:0] ctx_bytes,
   input wire scc_pkg::scc_sidx_t tok_slot,
   input wire logic [`SCC_NSLOT-1:0] ring_busy,
   input wire logic [3:0] tok_speed,
   input wire logic [7:0] tok_hub_slot,
   input wire logic tok_split,
   input wire logic ping_ok
);
   import scc_pkg::*;
   logic rd_w3, rd_hi, busy_seen; // last cycle's read and ring flag
   logic next_w3, next_hi, next_busy;
   // what the registered outputs answer to
   always_comb begin
      next_w3 = (rd_word == 4'h3);
      next_hi = (rd_word > 4'h3);
      next_busy = ring_busy[tok_slot];
   end
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rd_w3 <= 1'b0;
         rd_hi <= 1'b0;
         busy_seen <= 1'b0;
      end else begin
         rd_w3 <= next_w3;
         rd_hi <= next_hi;
         busy_seen <= next_busy;
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   chk_take_done: assert property (cmd_valid && cmd_ready |=> !cmd_ready ##1
      (cmd_done && cmd_ready)) else $error("done not two cycles after take");
   chk_done_pulse: assert property (cmd_done |=> !cmd_done)
      else $error("done longer than one cycle");
   chk_code_legal: assert property (cmd_done |-> cmd_code inside {8'h01, 8'h02, 8'h03})
      else $error("bad completion code");
   chk_code_hold: assert property (!cmd_done |-> $stable(cmd_code))
      else $error("code moved without done");
   chk_addr_range: assert property (cmd_done |-> cmd_addr <= 8'h7f)
      else $error("address out of range");
   chk_state_code: assert property (rd_w3 |-> rd_data[31:29] == 3'h0)
      else $error("reserved slot state");
   chk_addr_valid: assert property (rd_w3 |-> rd_addr_valid == (rd_data[31:28] == 4'h1))
      else $error("address valid flag wrong");
   chk_opaque_zero: assert property (rd_hi |-> rd_data == 32'h0000_0000)
      else $error("opaque word not zero");
   chk_ctx_size: assert property (1'b1 |=> ctx_bytes == ($past(ctx_size_64) ? 7'h40 : 7'h20))
      else $error("context size wrong");
   chk_split_src: assert property (tok_split |-> tok_speed inside {4'h1, 4'h2}
      && tok_hub_slot != 8'h00) else $error("split token without translator");
   chk_ping_gate: assert property (ping_ok |-> busy_seen)
      else $error("ping with empty rings");
   cover property (cmd_done && cmd_code == 8'h03);
   cover property (tok_split);
   cover property (ping_ok);
endmodule

bind scc_slot_ctx_checker scc_chk_sva u_chk (.clk, .rstn, .cmd_valid, .cmd_ready, .cmd_done,
   .cmd_code, .cmd_addr, .rd_word, .ctx_size_64, .rd_data, .rd_addr_valid, .ctx_bytes,
   .tok_slot, .ring_busy, .tok_speed, .tok_hub_slot, .tok_split, .ping_ok);

`default_nettype wire

// ### verification/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "scc_params.svh"

// ==========================================
// bench top
module tb_top;
   import scc_pkg::*;
   localparam scc_cmd_t c_ad = `SCC_CMD_ADDR_DEV;
   localparam scc_cmd_t c_ce = `SCC_CMD_CONFIG_EP;
   localparam scc_cmd_t c_ds = `SCC_CMD_DISABLE;
   logic clk, rstn, cmd_valid, cmd_set_addr_ok, ctx_size_64, cmd_ready, cmd_done;
   logic rd_addr_valid, tok_split, ping_ok;
   scc_cmd_t cmd_type;
   scc_sidx_t cmd_slot, rd_slot, tok_slot;
   scc_dw_t cmd_in_dw0, cmd_in_dw1, cmd_in_dw2, cmd_in_dw3, rd_data, d;
   logic [7:0] cmd_code, cmd_addr, tok_hub_slot, tok_port, m_val, m_tth;
   logic [3:0] rd_word, tok_speed, m_spd;
   logic [6:0] ctx_bytes;
   logic [15:0] tok_exlat;
   logic [`SCC_NSLOT-1:0] ring_busy;
   int n_fail, total_checks, cyc;
   scc_slot_ctx_checker dut_u (.clk, .rstn, .cmd_valid, .cmd_type, .cmd_slot, .cmd_in_dw0,
      .cmd_in_dw1, .cmd_in_dw2, .cmd_in_dw3, .cmd_set_addr_ok, .cmd_ready, .cmd_done,
      .cmd_code, .cmd_addr, .rd_slot, .rd_word, .ctx_size_64, .rd_data, .rd_addr_valid,
      .ctx_bytes, .tok_slot, .ring_busy, .tok_speed, .tok_hub_slot, .tok_port, .tok_split,
      .ping_ok, .tok_exlat);
   scc_sw_model sw_u (.cfg(cmd_type == c_ce), .speed(m_spd), .val(m_val), .tt_hub(m_tth),
      .dw0(cmd_in_dw0), .dw1(cmd_in_dw1), .dw2(cmd_in_dw2), .dw3(cmd_in_dw3));
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   // ==========================================
   // shared tasks
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("Error at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   // one command, done one edge after take
   task automatic cmd(input scc_cmd_t t, input scc_sidx_t s, input logic [3:0] spd,
      input logic [7:0] v, input logic [7:0] tth, input logic [7:0] exp);
      int i;
      i = 0;
      @(posedge clk);
      cmd_type <= t;
      cmd_slot <= s;
      m_spd <= spd;
      m_val <= v;
      m_tth <= tth;
      cmd_valid <= 1'b1;
      @(posedge clk);
      cmd_valid <= 1'b0;
      do begin
         @(posedge clk);
         #1;
         i++;
      end while (cmd_done !== 1'b1 && i < 8);
      chk(i, 1);
      chk(cmd_code, exp);
   endtask
   // read one word, token lookup follows the same slot
   task automatic rd(input scc_sidx_t s, input logic [3:0] w);
      @(posedge clk);
      rd_slot <= s;
      rd_word <= w;
      tok_slot <= s;
      @(posedge clk);
      #1 d = rd_data;
   endtask
   // ==========================================
   // scenarios
   task automatic t_reset;
      rd(0, 4'h3); chk(d, 32'h0);
      chk(rd_addr_valid, 1'b0);
      chk(ctx_bytes, 7'h20);
      cmd(c_ce, 0, `SCC_SPD_HS, 8'h00, 8'h00, 8'h03);
      rd(0, 4'h3); chk(d, 32'h0);
      $display("test reset done");
   endtask
   task automatic t_addr;
      cmd(c_ad, 0, `SCC_SPD_HS, 8'h01, 8'h00, 8'h01); chk(cmd_addr, 8'h01);
      rd(0, 4'h3); chk(d, 32'h1000_0001); chk(rd_addr_valid, 1'b1);
      cmd(c_ad, 1, `SCC_SPD_HS, 8'h01, 8'h00, 8'h01); chk(cmd_addr, 8'h02);
      cmd(c_ad, 2, `SCC_SPD_HS, 8'h02, 8'h00, 8'h01); chk(cmd_addr, 8'h01);
      cmd(c_ad, 4, `SCC_SPD_HS, 8'h00, 8'h00, 8'h02);
      cmd(c_ad, 4, `SCC_SPD_HS, 8'h09, 8'h00, 8'h02);
      cmd(c_ad, 0, `SCC_SPD_HS, 8'h01, 8'h00, 8'h03);
      @(posedge clk) cmd_set_addr_ok <= 1'b0;
      cmd(c_ad, 3, `SCC_SPD_HS, 8'h03, 8'h00, 8'h01); chk(cmd_addr, 8'h00);
      rd(3, 4'h3); chk(d, 32'h0800_0000); chk(rd_addr_valid, 1'b0);
      rd(3, 4'h0); chk(d, 32'h0830_0000);
      cmd(c_ds, 3, `SCC_SPD_HS, 8'h03, 8'h00, 8'h01);
      rd(3, 4'h3); chk(d, 32'h0);
      @(posedge clk) cmd_set_addr_ok <= 1'b1;
      $display("test address done");
   endtask
   task automatic t_cfg;
      cmd(c_ce, 0, `SCC_SPD_HS, 8'h04, 8'h00, 8'h01);
      rd(0, 4'h0); chk(d, 32'h1430_0000);
      rd(0, 4'h1); chk(d, 32'h0401_0000);
      rd(0, 4'h3); chk(d, 32'h1800_0001);
      cmd(`SCC_CMD_NOP, 0, 4'h0, 8'h00, 8'h00, 8'h01); rd(0, 4'h3); chk(d, 32'h1800_0001);
      cmd(c_ce, 1, `SCC_SPD_HS, 8'h00, 8'h00, 8'h01);
      cmd(c_ce, 1, `SCC_SPD_HS, 8'h00, 8'h00, 8'h01);
      rd(1, 4'h3); chk(d, 32'h1800_0002);
      $display("test configure done");
   endtask
   task automatic t_tok;
      cmd(c_ad, 5, `SCC_SPD_LS, 8'h01, 8'h01, 8'h01); chk(cmd_addr, 8'h03);
      rd(5, 4'h3); chk(tok_split, 1'b1); chk(tok_hub_slot, 8'h01);
      chk(tok_port, 8'h01); chk(tok_speed, `SCC_SPD_LS); chk(tok_exlat, 16'h0);
      cmd(c_ad, 6, `SCC_SPD_LS, 8'h01, 8'h02, 8'h02);
      @(posedge clk) ring_busy <= 8'h01;
      rd(0, 4'h3); chk(ping_ok, 1'b1);
      @(posedge clk) ring_busy <= 8'h00;
      rd(0, 4'h3); chk(ping_ok, 1'b0);
      @(posedge clk) ctx_size_64 <= 1'b1;
      rd(0, 4'h5); chk(d, 32'h0); chk(ctx_bytes, 7'h40);
      $display("test token done");
   endtask
   // ==========================================
   // end of run
   task automatic conclude;
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 3000) begin
         n_fail++;
         $display("Error at %0t: timeout", $time);
         conclude;
      end
   end
   initial begin
      {rstn, cmd_valid, ctx_size_64, rd_slot, rd_word, tok_slot, ring_busy} = '0;
      {cmd_type, cmd_slot, m_val, m_tth} = '0;
      cmd_set_addr_ok = 1'b1;
      m_spd = `SCC_SPD_HS;
      repeat (3) @(posedge clk);
      rstn <= 1'b1;
      repeat (2) @(posedge clk);
      t_reset;
      t_addr;
      t_cfg;
      t_tok;
      conclude;
   end
endmodule

`default_nettype wire
